// ---- rtl/see_pkg.sv ----
/*
 * Shared constants and types of the serial EEPROM command core.
 * Assumes a 20 MHz system clock; the link side runs on the host serial clock.
 */
package see_pkg;
	localparam int SYS_CLK_HZ      = 20000000;
	localparam int ADDR_W          = 11;
	localparam int WORD_CYCLE_US   = 3000;
	localparam int BULK_ERASE_US   = 8000;
	localparam int BULK_FILL_US    = 16000;
	localparam int WORD_CYCLE_CLKS = WORD_CYCLE_US * (SYS_CLK_HZ / 1000000);
	localparam int BULK_ERASE_CLKS = BULK_ERASE_US * (SYS_CLK_HZ / 1000000);
	localparam int BULK_FILL_CLKS  = BULK_FILL_US * (SYS_CLK_HZ / 1000000);
	localparam int DESELECT_GAP_NS = 250;
	localparam logic [1:0] OP_EXT   = 2'h0;
	localparam logic [1:0] OP_WRITE = 2'h1;
	localparam logic [1:0] OP_READ  = 2'h2;
	localparam logic [1:0] OP_ERASE = 2'h3;
	localparam logic [1:0] EXT_LOCK   = 2'h0;
	localparam logic [1:0] EXT_FILL   = 2'h1;
	localparam logic [1:0] EXT_BERASE = 2'h2;
	localparam logic [1:0] EXT_UNLOCK = 2'h3;
	localparam logic [15:0] ERASED_WORD = 16'hFFFF;

	typedef enum logic [1:0] {
		SEE_PROG_WORD,
		SEE_PROG_ERASE_ALL,
		SEE_PROG_FILL_ALL
	} see_prog_kind_t;

	typedef struct packed {
		see_prog_kind_t      kind;
		logic [ADDR_W-1:0]   addr;
		logic [15:0]         data;
	} see_prog_req_t;
endpackage : see_pkg

// ---- rtl/see_prog_timer.sv ----
/*
 * Self-timed programming engine: applies one program request to the array
 * through a write port and holds busy for the documented cycle time.
 * Assumes the request arrives as a level-stable struct with a toggle event.
 */
`timescale 1ns/100ps
`default_nettype none
module see_prog_timer #(
	parameter int WORD_CLKS  = see_pkg::WORD_CYCLE_CLKS,
	parameter int ERASE_CLKS = see_pkg::BULK_ERASE_CLKS,
	parameter int FILL_CLKS  = see_pkg::BULK_FILL_CLKS,
	parameter int DEPTH      = 2048
) (
	input  wire logic                  clk_in,
	input  wire logic                  rst_in,
	input  wire logic                  start_in,
	input  wire see_pkg::see_prog_req_t req_in,
	output logic                       busy_out,
	output logic                       wr_en_out,
	output logic [see_pkg::ADDR_W-1:0] wr_addr_out,
	output logic [15:0]                wr_data_out
);
	// A bulk sweep writes one location per clock, so a bulk cycle shorter
	// than the array could never reach its last location.
	initial begin
		if (WORD_CLKS < 1 || ERASE_CLKS < DEPTH || FILL_CLKS < DEPTH || DEPTH < 1 ||
				DEPTH > 2048)
			$error("see_prog_timer: bad timing or depth parameter");
	end

	logic [31:0]                count_r;
	logic [see_pkg::ADDR_W-1:0] sweep_r;
	logic                       bulk_r;
	logic                       sweep_end_r;
	logic [31:0]                len;

	assign len = (req_in.kind == see_pkg::SEE_PROG_WORD) ? 32'(WORD_CLKS) :
		(req_in.kind == see_pkg::SEE_PROG_ERASE_ALL) ? 32'(ERASE_CLKS) : 32'(FILL_CLKS);
	assign busy_out    = (count_r != 32'h0);
	assign wr_en_out   = busy_out && !(bulk_r && sweep_end_r);
	assign wr_addr_out = bulk_r ? sweep_r : req_in.addr;
	assign wr_data_out = (req_in.kind == see_pkg::SEE_PROG_ERASE_ALL) ? see_pkg::ERASED_WORD :
		req_in.data;

	// A bulk sweep walks every location once; a fill writes data, which
	// also covers the automatic erase that precedes it.
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			count_r     <= 32'h0;
			sweep_r     <= '0;
			bulk_r      <= 1'b0;
			sweep_end_r <= 1'b0;
		end else if (start_in && !busy_out) begin
			count_r     <= len;
			sweep_r     <= '0;
			bulk_r      <= (req_in.kind != see_pkg::SEE_PROG_WORD);
			sweep_end_r <= 1'b0;
		end else if (busy_out) begin
			count_r <= count_r - 32'h1;
			if (bulk_r && !sweep_end_r) begin
				if (sweep_r == see_pkg::ADDR_W'(DEPTH - 1))
					sweep_end_r <= 1'b1;
				else
					sweep_r <= sweep_r + see_pkg::ADDR_W'(1);
			end
		end
	end
endmodule : see_prog_timer
`default_nettype wire

// ---- rtl/see_core.sv ----
/*
 * Command core of a three-wire serial EEPROM: serial shifter on the host
 * clock, lock state, array storage and the self-timed programming engine.
 * Assumes the host serial clock and select arrive unrelated to SYS_CLK_IN.
 */
// Notes on behaviour
// [R01] Start locked after reset.
// [R02] Programming needs unlock; lock ends it.
// [R03] Reads work locked or unlocked.
// [R04] Read sends zero then word.
// [R05] Read bits change on rising clock.
// [R06] Held select continues sequential read.
// [R07] Word erase sets ones after address.
// [R08] Word write starts after last data.
// [R09] Programming cycle ignores link inputs.
// [R10] Status shows busy low, ready high.
// [R11] Deselect releases output, enters standby.
// [R12] Word cycle about three milliseconds.
// [R13] Bulk erase sets all ones.
// [R14] Bulk fill erases then writes all.
// [R15] Low select holds control in reset.
// [R16] Inputs captured on rising clock.
// [R17] Paused clock is tolerated.
// [R18] Clocks before start bit change nothing.
// [R19] Host deselects between instructions.
// [R20] Width select high chooses sixteen bits.
// [R21] Low program enable blocks programming.
// [R22] Start bit is select and input high.
// [R23] Execute only after all bits.
// [R24] Two-bit opcode plus extended codes.
`timescale 1ns/100ps
`default_nettype none
module see_core #(
	parameter int WORD_CLKS  = see_pkg::WORD_CYCLE_CLKS,
	parameter int ERASE_CLKS = see_pkg::BULK_ERASE_CLKS,
	parameter int FILL_CLKS  = see_pkg::BULK_FILL_CLKS,
	parameter int DEPTH      = 2048
) (
	input  wire logic SYS_CLK_IN,
	input  wire logic RST_IN,
	input  wire logic LINK_CLK_IN,
	input  wire logic SELECT_IN,
	input  wire logic SERIAL_IN,
	input  wire logic WORD_WIDTH_SELECT_IN,
	input  wire logic PROGRAM_ENABLE_INPUT_IN,
	output logic      SERIAL_OUT,
	output logic      SERIAL_OE_OUT,
	output logic      UNLOCKED_OUT,
	output logic      BUSY_OUT
);
	initial begin
		if (DEPTH != 2048)
			$error("see_core: array depth must be 2048 bytes");
	end

	typedef enum logic [2:0] {
		SEE_IDLE,
		SEE_OPCODE,
		SEE_ADDR,
		SEE_DATA,
		SEE_READ,
		SEE_STATUS,
		SEE_DONE
	} see_link_state_t;

	////////////////////////////////////////////////////////////////////////
	// Array and system-domain programming.

	logic [7:0] mem_r [0:DEPTH-1];
	logic       wr_en;
	logic [see_pkg::ADDR_W-1:0] wr_addr;
	logic [15:0] wr_data;
	logic       eng_busy;
	logic       wide_sys;

	// The array is byte wide; a wide word occupies two bytes, high first.
	always_ff @(posedge SYS_CLK_IN) begin
		if (wr_en) begin
			if (wide_sys) begin
				mem_r[{wr_addr[see_pkg::ADDR_W-2:0], 1'b0}] <= wr_data[15:8];
				mem_r[{wr_addr[see_pkg::ADDR_W-2:0], 1'b1}] <= wr_data[7:0];
			end else begin
				mem_r[wr_addr] <= wr_data[7:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Link domain. Select low is an asynchronous reset of the shifter, so
	// the shifter simply stops wherever the host pauses the clock.

	logic                       link_rst;
	see_link_state_t            st_r;
	logic [4:0]                 cnt_r;
	logic [1:0]                 op_r;
	logic [see_pkg::ADDR_W-1:0] addr_r;
	logic [15:0]                data_r;
	logic [16:0]                rd_sh_r;
	logic                       wide_l1_r;
	logic                       wide_l2_r;
	logic                       pe_l1_r;
	logic                       pe_l2_r;
	logic                       unlock_r;
	logic                       req_tgl_r;
	see_pkg::see_prog_req_t     req_r;
	logic                       busy_l1_r;
	logic                       busy_l2_r;
	logic                       wide;
	logic [4:0]                 addr_bits;
	logic [4:0]                 data_bits;
	logic [1:0]                 ext_code;
	logic                       prog_ok;
	logic [see_pkg::ADDR_W-1:0] addr_nxt;
	logic [see_pkg::ADDR_W-1:0] rd_ptr_nxt;
	logic [15:0]                rd_word;
	logic                       last_addr;
	logic                       last_data;
	logic                       last_read;

	assign link_rst  = RST_IN || !SELECT_IN; // [R15] [R11]
	assign wide      = wide_l2_r; // [R20]
	assign addr_bits = wide ? 5'h0A : 5'h0B;
	assign data_bits = wide ? 5'h10 : 5'h08;
	assign prog_ok   = unlock_r && pe_l2_r; // [R02] [R21]
	assign addr_nxt  = {addr_r[see_pkg::ADDR_W-2:0], SERIAL_IN}; // [R16]
	// The extended code is carried in the two most significant address bits.
	assign ext_code  = wide ? addr_nxt[see_pkg::ADDR_W-2:see_pkg::ADDR_W-3] :
		addr_nxt[see_pkg::ADDR_W-1:see_pkg::ADDR_W-2]; // [R24]
	assign last_addr = (st_r == SEE_ADDR) && (cnt_r == addr_bits - 5'h1);
	assign last_data = (st_r == SEE_DATA) && (cnt_r == data_bits - 5'h1);
	assign last_read = (st_r == SEE_READ) && (cnt_r == data_bits);
	assign rd_ptr_nxt = last_addr ? addr_nxt : addr_r + see_pkg::ADDR_W'(1); // [R06]

	// Narrow mode uses all eleven bits; wide mode uses the low ten.
	logic [see_pkg::ADDR_W-1:0] byte_ad;
	assign byte_ad = wide ? {rd_ptr_nxt[see_pkg::ADDR_W-2:0], 1'b0} : rd_ptr_nxt;
	assign rd_word = wide ? {mem_r[byte_ad], mem_r[byte_ad | see_pkg::ADDR_W'(1)]} :
		{8'h00, mem_r[byte_ad]};

	// The lock bit survives deselect, so only the system reset or a lock instruction clears it.
	always_ff @(posedge LINK_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			unlock_r <= 1'b0; // [R01]
		end else if (SELECT_IN && last_addr && op_r == see_pkg::OP_EXT) begin // [R23]
			if (ext_code == see_pkg::EXT_UNLOCK)
				unlock_r <= 1'b1; // [R02]
			else if (ext_code == see_pkg::EXT_LOCK)
				unlock_r <= 1'b0; // [R02]
		end
	end

	// The request toggle and its payload also survive deselect, because a
	// started programming cycle must complete regardless of select.
	always_ff @(posedge LINK_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			req_tgl_r <= 1'b0;
			req_r     <= '0;
		end else if (SELECT_IN && prog_ok && !busy_l2_r) begin
			if (last_addr && op_r == see_pkg::OP_ERASE) begin
				req_r     <= '{see_pkg::SEE_PROG_WORD, addr_nxt, see_pkg::ERASED_WORD}; // [R07]
				req_tgl_r <= !req_tgl_r;
			end else if (last_addr && op_r == see_pkg::OP_EXT &&
					ext_code == see_pkg::EXT_BERASE) begin
				req_r     <= '{see_pkg::SEE_PROG_ERASE_ALL, '0, see_pkg::ERASED_WORD}; // [R13]
				req_tgl_r <= !req_tgl_r;
			end else if (last_data) begin
				req_r.kind <= (op_r == see_pkg::OP_WRITE) ? see_pkg::SEE_PROG_WORD :
					see_pkg::SEE_PROG_FILL_ALL; // [R08] [R14]
				req_r.addr <= addr_r;
				req_r.data <= {data_r[14:0], SERIAL_IN};
				req_tgl_r  <= !req_tgl_r;
			end
		end
	end

	always_ff @(posedge LINK_CLK_IN or posedge link_rst) begin
		if (link_rst) begin
			st_r    <= SEE_IDLE;
			cnt_r   <= 5'h0;
			op_r    <= 2'h0;
			addr_r  <= '0;
			data_r  <= 16'h0;
			rd_sh_r <= 17'h0;
		end else begin
			cnt_r <= cnt_r + 5'h1;
			case (st_r)
				SEE_IDLE: begin
					cnt_r <= 5'h0;
					if (SERIAL_IN)
						st_r <= SEE_OPCODE; // [R22] [R18]
				end
				SEE_OPCODE: begin
					op_r <= {op_r[0], SERIAL_IN}; // [R24]
					if (cnt_r == 5'h1) begin
						st_r  <= SEE_ADDR;
						cnt_r <= 5'h0;
					end
				end
				SEE_ADDR: begin
					addr_r <= addr_nxt;
					if (last_addr) begin
						cnt_r <= 5'h0;
						if (op_r == see_pkg::OP_READ) begin
							st_r    <= SEE_READ; // [R03]
							rd_sh_r <= {1'b0, wide ? rd_word : {rd_word[7:0], 8'h00}}; // [R04]
						end else if (op_r == see_pkg::OP_WRITE ||
								(op_r == see_pkg::OP_EXT && ext_code == see_pkg::EXT_FILL))
							st_r <= SEE_DATA;
						else if (op_r == see_pkg::OP_ERASE || ext_code == see_pkg::EXT_BERASE)
							st_r <= SEE_STATUS; // [R10]
						else
							st_r <= SEE_DONE; // [R23]
					end
				end
				SEE_DATA: begin
					data_r <= {data_r[14:0], SERIAL_IN};
					if (last_data)
						st_r <= SEE_STATUS; // [R10]
				end
				SEE_READ: begin
					rd_sh_r <= {rd_sh_r[15:0], 1'b0}; // [R05]
					if (last_read) begin
						addr_r  <= rd_ptr_nxt; // [R06]
						cnt_r   <= 5'h1;
						rd_sh_r <= {wide ? rd_word : {rd_word[7:0], 8'h00}, 1'b0};
					end
				end
				SEE_STATUS: begin
					cnt_r <= 5'h0;
					if (SERIAL_IN && !busy_l2_r)
						st_r <= SEE_OPCODE; // [R10] [R22]
				end
				default: begin
					cnt_r <= 5'h0; // [R09] [R17]
				end
			endcase
		end
	end

	// Width and enable pins pass two flip-flops on the link clock. That clock
	// only runs inside frames, so a pin changed while deselected takes effect
	// from the third edge of the next frame, before any address bit counts.
	always_ff @(posedge LINK_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			wide_l1_r <= 1'b1;
			wide_l2_r <= 1'b1;
			pe_l1_r   <= 1'b1;
			pe_l2_r   <= 1'b1;
		end else begin
			wide_l1_r <= WORD_WIDTH_SELECT_IN; // [R20]
			wide_l2_r <= wide_l1_r;
			pe_l1_r   <= PROGRAM_ENABLE_INPUT_IN; // [R21]
			pe_l2_r   <= pe_l1_r;
		end
	end

	// Busy is brought into the link domain with two flip-flops.
	always_ff @(posedge LINK_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			busy_l1_r <= 1'b0;
			busy_l2_r <= 1'b0;
		end else begin
			busy_l1_r <= eng_busy;
			busy_l2_r <= busy_l1_r;
		end
	end

	assign SERIAL_OE_OUT = SELECT_IN && (st_r == SEE_READ || st_r == SEE_STATUS); // [R11]
	assign SERIAL_OUT    = (st_r == SEE_READ) ? rd_sh_r[16] : !busy_l2_r; // [R10] [R04]

	////////////////////////////////////////////////////////////////////////
	// System domain: toggle crossing of the request, then the engine.

	logic       tgl_s1_r;
	logic       tgl_s2_r;
	logic       tgl_s3_r;
	logic       wide_s1_r;
	logic       wide_s2_r;
	logic       unl_s1_r;
	logic       unl_s2_r;

	always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			tgl_s1_r  <= 1'b0;
			tgl_s2_r  <= 1'b0;
			tgl_s3_r  <= 1'b0;
			wide_s1_r <= 1'b1;
			wide_s2_r <= 1'b1;
			unl_s1_r  <= 1'b0;
			unl_s2_r  <= 1'b0;
		end else begin
			tgl_s1_r  <= req_tgl_r;
			tgl_s2_r  <= tgl_s1_r;
			tgl_s3_r  <= tgl_s2_r;
			wide_s1_r <= WORD_WIDTH_SELECT_IN;
			wide_s2_r <= wide_s1_r;
			unl_s1_r  <= unlock_r;
			unl_s2_r  <= unl_s1_r;
		end
	end

	assign wide_sys     = wide_s2_r;
	assign UNLOCKED_OUT = unl_s2_r;
	assign BUSY_OUT     = eng_busy;

	see_prog_timer #(
		.WORD_CLKS  (WORD_CLKS),
		.ERASE_CLKS (ERASE_CLKS),
		.FILL_CLKS  (FILL_CLKS),
		.DEPTH      (DEPTH)
	) u_timer (
		.clk_in      (SYS_CLK_IN),
		.rst_in      (RST_IN),
		.start_in    (tgl_s2_r ^ tgl_s3_r), // [R12] [R09]
		.req_in      (req_r),
		.busy_out    (eng_busy),
		.wr_en_out   (wr_en),
		.wr_addr_out (wr_addr),
		.wr_data_out (wr_data)
	);
endmodule : see_core
`default_nettype wire

// ---- tb/see_checker.sv ----
/* Concurrent checks on the see_core ports.
   Assumes a bind from the bench top with the cycle parameters handed on. */
`timescale 1ns/100ps
`default_nettype none
module see_checker #(
	parameter int WORD_CLKS = 20,
	parameter int FILL_CLKS = 60
) (
	input wire logic SYS_CLK_IN,
	input wire logic RST_IN,
	input wire logic LINK_CLK_IN,
	input wire logic SELECT_IN,
	input wire logic PROGRAM_ENABLE_INPUT_IN,
	input wire logic SERIAL_OUT,
	input wire logic SERIAL_OE_OUT,
	input wire logic UNLOCKED_OUT,
	input wire logic BUSY_OUT
);
	int busy_cnt_r;
	always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
		if (RST_IN)
			busy_cnt_r <= 0;
		else
			busy_cnt_r <= BUSY_OUT ? busy_cnt_r + 1 : 0;
	end
	////////////////////////////////////////////////////////////////
	property p_reset_state;
		@(posedge SYS_CLK_IN) RST_IN |-> !UNLOCKED_OUT && !BUSY_OUT && !SERIAL_OE_OUT;
	endproperty
	a_reset_state: assert property (p_reset_state)
		else $error("state not cleared in reset");
	property p_desel_quiet;
		@(posedge SYS_CLK_IN) disable iff (RST_IN) !SELECT_IN |-> !SERIAL_OE_OUT;
	endproperty
	a_desel_quiet: assert property (p_desel_quiet)
		else $error("output driven while deselected");
	property p_pe_block;
		@(posedge SYS_CLK_IN) disable iff (RST_IN) $rose(BUSY_OUT) |-> PROGRAM_ENABLE_INPUT_IN;
	endproperty
	a_pe_block: assert property (p_pe_block)
		else $error("programming with enable low");
	property p_lock_block;
		@(posedge SYS_CLK_IN) disable iff (RST_IN) $rose(BUSY_OUT) |-> UNLOCKED_OUT;
	endproperty
	a_lock_block: assert property (p_lock_block)
		else $error("programming while locked");
	property p_busy_len;
		@(posedge SYS_CLK_IN) disable iff (RST_IN)
			$fell(BUSY_OUT) |-> busy_cnt_r >= WORD_CLKS && busy_cnt_r <= FILL_CLKS + 8;
	endproperty
	a_busy_len: assert property (p_busy_len)
		else $error("cycle length out of range");
	property p_busy_hold;
		@(posedge SYS_CLK_IN) disable iff (RST_IN) $rose(BUSY_OUT) |-> BUSY_OUT[*8];
	endproperty
	a_busy_hold: assert property (p_busy_hold)
		else $error("cycle cut short");
	property p_status_busy;
		@(posedge LINK_CLK_IN) disable iff (RST_IN || !SELECT_IN)
			BUSY_OUT && $past(BUSY_OUT, 3) && SERIAL_OE_OUT && $past(SERIAL_OE_OUT, 3)
			|-> !SERIAL_OUT;
	endproperty
	a_status_busy: assert property (p_status_busy)
		else $error("status ready while busy");
	property p_oe_select;
		@(posedge SYS_CLK_IN) disable iff (RST_IN) $rose(SERIAL_OE_OUT) |-> SELECT_IN;
	endproperty
	a_oe_select: assert property (p_oe_select)
		else $error("output enabled without select");
	c_busy: cover property (@(posedge SYS_CLK_IN) $rose(BUSY_OUT));
	c_read: cover property (@(posedge SYS_CLK_IN) $rose(SERIAL_OE_OUT) && !BUSY_OUT);
	c_unlock: cover property (@(posedge SYS_CLK_IN) $rose(UNLOCKED_OUT));
endmodule : see_checker
`default_nettype wire

// ---- tb/see_host_model.sv ----
/* Host controller model driving the three-wire link.
   Assumes a 64 ns link clock that stands still between frames. */
`timescale 1ns/100ps
`default_nettype none
module see_host_model (
	output logic      link_clk_out,
	output logic      select_out,
	output logic      serial_in_out,
	input  wire logic serial_out_in,
	input  wire logic serial_oe_in
);
	initial begin
		link_clk_out = 1'b0;
		select_out = 1'b1;
		serial_in_out = 1'b0;
		// Select stands high while reset rises, so that the reset reaches the
		// link logic as an edge; it drops long before the first clock pulse.
		#2 select_out = 1'b0;
	end
	task pulse(output logic s);
		#32 link_clk_out = 1'b1;
		#16 s = serial_oe_in ? serial_out_in : 1'bz;
		#16 link_clk_out = 1'b0;
	endtask : pulse
	// Bits go out MSB first; after them the input toggles as a don't-care.
	task xfer(input logic [31:0] bits, input int n, input int n_rd, output logic [63:0] rd);
		logic s;
		rd = '0;
		select_out = 1'b1;
		for (int i = n - 1; i >= -n_rd; i--) begin
			serial_in_out = (i >= 0) ? bits[i] : ~serial_in_out;
			pulse(s);
			if (i <= 0)
				rd = {rd[62:0], s};
		end
	endtask : xfer
	task poll(output logic ok);
		logic s;
		logic low;
		low = 1'b0;
		ok = 1'b0;
		serial_in_out = 1'b0;
		for (int k = 0; k < 4000 && !ok; k++) begin
			pulse(s);
			low |= (s === 1'b0);
			ok = low && (s === 1'b1);
		end
	endtask : poll
	task desel();
		select_out = 1'b0;
		serial_in_out = ~serial_in_out;
		#300;
	endtask : desel
endmodule : see_host_model
`default_nettype wire

// ---- tb/test_serial_eeprom_command_core.sv ----
/* Self-checking bench for see_core with a host link model.
   Assumes shortened cycle counts; expectations follow from them. */
`timescale 1ns/100ps
`default_nettype none
module test_serial_eeprom_command_core;
	logic        sys_clk = 1'b0;
	logic        rst     = 1'b0;
	logic        width   = 1'b1;
	logic        prog_en = 1'b1;
	logic        ok;
	logic [63:0] rd;
	wire         link_clk, sel, sdi, sdo, sdo_oe, unlocked, busy;
	int          n_fail = 0;
	int          total_checks = 0;
	always #25 sys_clk = ~sys_clk;
	see_core #(.WORD_CLKS(20), .ERASE_CLKS(2100), .FILL_CLKS(2200)) i_dut (
		.SYS_CLK_IN(sys_clk), .RST_IN(rst), .LINK_CLK_IN(link_clk), .SELECT_IN(sel),
		.SERIAL_IN(sdi), .WORD_WIDTH_SELECT_IN(width), .PROGRAM_ENABLE_INPUT_IN(prog_en),
		.SERIAL_OUT(sdo), .SERIAL_OE_OUT(sdo_oe), .UNLOCKED_OUT(unlocked), .BUSY_OUT(busy));
	see_host_model i_host (.link_clk_out(link_clk), .select_out(sel), .serial_in_out(sdi),
		.serial_out_in(sdo), .serial_oe_in(sdo_oe));
	////////////////////////////////////////////////////////////////
	task chk(input logic [63:0] got, input logic [63:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask : chk
	task cmd(input logic [31:0] bits, input int n);
		i_host.xfer(bits, n, 0, rd);
		i_host.desel();
		chk(busy, 1'b0);
		repeat (20) @(negedge sys_clk);
	endtask : cmd
	task prog(input logic [31:0] bits, input int n);
		i_host.xfer(bits, n, 0, rd);
		i_host.poll(ok);
		chk(ok, 1);
		i_host.desel();
	endtask : prog
	task rdw(input logic [31:0] bits, input int n, input int n_rd, input logic [63:0] exp);
		i_host.xfer(bits, n, n_rd, rd);
		chk(rd, exp);
		i_host.desel();
	endtask : rdw
	task test_done();
		if (n_fail == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : test_done
	////////////////////////////////////////////////////////////////
	task t_locked();
		chk({unlocked, busy, sdo_oe}, 0);
		cmd({3'b101, 10'h005, 16'hABCD}, 29);
		chk(busy, 0);
		chk(sdo_oe, 0);
	endtask : t_locked
	task t_program();
		cmd({3'b100, 2'b11, 8'h00}, 13);
		chk(unlocked, 1);
		prog({3'b101, 10'h005, 16'h1234}, 29);
		i_host.xfer({3'b101, 10'h006, 16'h5678}, 29, 0, rd);
		i_host.desel();
		chk(busy, 1);
		for (int k = 0; k < 200 && busy !== 1'b0; k++)
			@(negedge sys_clk);
		chk(busy, 0);
		rdw({3'b110, 10'h005}, 13, 32, 64'h12345678);
	endtask : t_program
	task t_lock();
		cmd({3'b100, 2'b00, 8'h00}, 13);
		cmd({3'b101, 10'h005, 16'hABCD}, 29);
		chk(busy, 0);
		rdw({3'b110, 10'h005}, 13, 16, 64'h1234);
	endtask : t_lock
	task t_bulk();
		cmd({3'b100, 2'b11, 8'h00}, 13);
		prog({3'b111, 10'h006}, 13);
		rdw({3'b110, 10'h006}, 13, 16, 64'hFFFF);
		prog({3'b100, 2'b10, 8'h5A}, 13);
		rdw({3'b110, 10'h005}, 13, 16, 64'hFFFF);
		prog({3'b100, 2'b01, 8'hA5, 16'h0F0F}, 29);
		rdw({3'b110, 10'h3FF}, 13, 16, 64'h0F0F);
	endtask : t_bulk
	task t_pe_low();
		@(negedge sys_clk) prog_en = 1'b0;
		cmd({3'b101, 10'h005, 16'h1111}, 29);
		chk(busy, 0);
		@(negedge sys_clk) prog_en = 1'b1;
		rdw({3'b110, 10'h005}, 13, 16, 64'h0F0F);
	endtask : t_pe_low
	task t_narrow();
		@(negedge sys_clk) width = 1'b0;
		rdw({2'b00, 3'b110, 11'h7FF}, 16, 8, 64'h0F);
		@(negedge sys_clk) width = 1'b1;
	endtask : t_narrow
	task t_reset();
		cmd({3'b100, 2'b11, 8'h00}, 13);
		chk(unlocked, 1);
		@(negedge sys_clk) rst = 1'b1;
		repeat (2) @(negedge sys_clk);
		rst = 1'b0;
		chk(unlocked, 0);
		cmd({3'b101, 10'h005, 16'h2222}, 29);
		rdw({3'b110, 10'h005}, 13, 16, 64'h0F0F);
	endtask : t_reset
	////////////////////////////////////////////////////////////////
	// Reset rises after time zero, so that the asynchronous resets see an edge.
	initial begin
		#1 rst = 1'b1;
		repeat (2) @(posedge sys_clk);
		@(negedge sys_clk) rst = 1'b0;
		t_locked();
		t_program();
		t_lock();
		t_bulk();
		t_pe_low();
		t_narrow();
		t_reset();
		test_done();
	end
	initial begin
		#600us;
		n_fail++;
		test_done();
	end
endmodule : test_serial_eeprom_command_core
bind see_core see_checker #(.WORD_CLKS(WORD_CLKS), .FILL_CLKS(FILL_CLKS)) i_chk (
	.SYS_CLK_IN(SYS_CLK_IN), .RST_IN(RST_IN), .LINK_CLK_IN(LINK_CLK_IN),
	.SELECT_IN(SELECT_IN), .PROGRAM_ENABLE_INPUT_IN(PROGRAM_ENABLE_INPUT_IN),
	.SERIAL_OUT(SERIAL_OUT), .SERIAL_OE_OUT(SERIAL_OE_OUT),
	.UNLOCKED_OUT(UNLOCKED_OUT), .BUSY_OUT(BUSY_OUT));
`default_nettype wire
